// ### hw/ulsh_map.svh
// Offsets, field positions and reset values of the legacy-support registers
// Assumes byte offsets in configuration space, dword aligned
`ifndef ULSH_MAP_SVH
`define ULSH_MAP_SVH
`define ULSH_CAP_OFFSET 8'h68
`define ULSH_CS_OFFSET 8'h6c
`define ULSH_CAP_RESET 32'h00000001
`define ULSH_CS_RESET 32'h00000000
`define ULSH_CAP_ID 8'h01
`define ULSH_CAP_NEXT 8'h00
`define ULSH_OS_OWN_BIT 24
`define ULSH_FW_OWN_BIT 16
`define ULSH_BAR_FLAG_BIT 31
`define ULSH_CMD_FLAG_BIT 30
`define ULSH_OWN_FLAG_BIT 29
`define ULSH_MIRROR_LSB 16
`define ULSH_BAR_EN_BIT 15
`define ULSH_CMD_EN_BIT 14
`define ULSH_OWN_EN_BIT 13
`define ULSH_MIRROR_W 6
`endif

// ### hw/ulsh_pkg.sv
// Types shared by the legacy-support register bank
// Assumes the map header for all numeric constants
package ulsh_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ulsh_cfg_req_t;
  typedef struct packed {
    logic [5:0] en;
    logic [5:0] flag;
  } ulsh_mirror_t;
endpackage : ulsh_pkg

// ### hw/ulsh_smi_gate.sv
// Gates mirrored host status flags with their enables
// Assumes flags and enables already registered in the sys_clk domain
`timescale 1ns/10ps
module ulsh_smi_gate
  import ulsh_pkg::*;
(
  input wire ulsh_mirror_t mir,
  output logic any_hit
);
  logic [5:0] hit;
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_gate
      assign hit[i] = mir.en[i] & mir.flag[i]; // see R23
    end
  endgenerate
  assign any_hit = |hit;
endmodule : ulsh_smi_gate

// ### hw/ulsh_legacy_handoff.sv
// Legacy-support capability and control/status register pair with SMI output
// Assumes a config-space port synchronous to sys_clk; resetn is the suspend-well reset
// Function
// R1 - OS sets bit 24 to request controller ownership; resets to zero.
// R2 - Ownership granted only when OS bit reads one and firmware bit zero; os_owned follows bit 24 alone, even while bit 16 is set.
// R3 - Firmware sets bit 16 to claim, clears it on OS request.
// R4 - Capability bits 15:8 read constant next pointer zero.
// R5 - Capability bits 7:0 read constant identifier one.
// R6 - Reserved capability bits read zero and ignore writes.
// R7 - Capability register kept in resume well; core resets do not clear it.
// R8 - Control/status clears only on suspend reset, survives core resets.
// R9 - Base address register write sets flag bit 31.
// R10 - Command register write sets flag bit 30.
// R11 - Any change of OS ownership bit sets flag bit 29.
// R12 - Flags 31, 30, 29 clear only by writing one.
// R13 - Bit 21 mirrors host status async-advance flag.
// R14 - Bit 20 mirrors host status system error flag.
// R15 - Bit 19 mirrors host status frame list rollover flag.
// R16 - Bit 18 mirrors host status port change flag.
// R17 - Bit 17 mirrors host status transfer error flag.
// R18 - Bit 16 mirrors host status transfer complete flag.
// R19 - Mirror bits clear at their host status source; mirror writes ignored.
// R20 - SMI while enable 15 and base-address flag both set.
// R21 - SMI while enable 14 and command flag both set.
// R22 - SMI while enable 13 and ownership-change flag both set.
// R23 - Enables 5:0 gate mirrored flags 21:16 onto SMI.
// R24 - SMI is OR of all enabled flag pairs, held until cleared.
// R25 - Writing zero leaves flags; read-only and reserved bits ignore writes.
`timescale 1ns/10ps
`include "ulsh_map.svh"
module ulsh_legacy_handoff
  import ulsh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire ulsh_cfg_req_t cfg_req,
  input wire logic bar_write,
  input wire logic cmd_write,
  input wire logic [5:0] host_status_flags,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic smi_out,
  output logic os_owned,
  output logic fw_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  localparam logic [31:0] cap_rst = `ULSH_CAP_RESET;
  localparam logic [31:0] cs_rst = `ULSH_CS_RESET;
  logic os_own_r;
  logic os_own_nxt;
  logic fw_own_r;
  logic fw_own_nxt;
  logic bar_flag_r;
  logic bar_flag_nxt;
  logic cmd_flag_r;
  logic cmd_flag_nxt;
  logic own_flag_r;
  logic own_flag_nxt;
  logic bar_en_r;
  logic bar_en_nxt;
  logic cmd_en_r;
  logic cmd_en_nxt;
  logic own_en_r;
  logic own_en_nxt;
  logic [5:0] mir_en_r;
  logic [5:0] mir_en_nxt;
  logic [5:0] mirror_r;
  logic [5:0] mirror_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic smi_r;
  logic smi_nxt;
  logic wr_cap;
  logic wr_cs;
  logic mir_hit;
  logic bar_clr;
  logic cmd_clr;
  logic own_clr;
  logic own_chg;
  logic bar_hit;
  logic cmd_hit;
  logic own_hit;
  wire [31:0] wmask;
  logic [31:0] wd;
  logic [31:0] cap_val;
  logic [31:0] cs_val;
  ulsh_mirror_t mir;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{cfg_req.be[lane]}};
    end
  endgenerate
  assign wd = cfg_req.wdata & wmask;
  assign wr_cap = cfg_req.wr && (cfg_req.addr == `ULSH_CAP_OFFSET);
  assign wr_cs = cfg_req.wr && (cfg_req.addr == `ULSH_CS_OFFSET);

  always_comb begin
    cap_val = 32'h00000000; // see R6
    cap_val[`ULSH_OS_OWN_BIT] = os_own_r;
    cap_val[`ULSH_FW_OWN_BIT] = fw_own_r;
    cap_val[15:8] = `ULSH_CAP_NEXT; // see R4
    cap_val[7:0] = `ULSH_CAP_ID; // see R5
  end

  always_comb begin
    cs_val = 32'h00000000;
    cs_val[`ULSH_BAR_FLAG_BIT] = bar_flag_r;
    cs_val[`ULSH_CMD_FLAG_BIT] = cmd_flag_r;
    cs_val[`ULSH_OWN_FLAG_BIT] = own_flag_r;
    cs_val[21:16] = mirror_r; // see R13 see R14 see R15 see R16 see R17 see R18
    cs_val[`ULSH_BAR_EN_BIT] = bar_en_r;
    cs_val[`ULSH_CMD_EN_BIT] = cmd_en_r;
    cs_val[`ULSH_OWN_EN_BIT] = own_en_r;
    cs_val[5:0] = mir_en_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ownership semaphores, resume well
  always_comb begin
    os_own_nxt = os_own_r;
    fw_own_nxt = fw_own_r;
    if (wr_cap && cfg_req.be[3]) begin
      os_own_nxt = wd[`ULSH_OS_OWN_BIT]; // see R1
    end
    if (wr_cap && cfg_req.be[2]) begin
      fw_own_nxt = wd[`ULSH_FW_OWN_BIT]; // see R3
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R7
    if (!resetn) begin
      os_own_r <= cap_rst[`ULSH_OS_OWN_BIT];
      fw_own_r <= cap_rst[`ULSH_FW_OWN_BIT];
    end else begin
      os_own_r <= os_own_nxt;
      fw_own_r <= fw_own_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SMI enables in lanes 1 and 0
  always_comb begin
    bar_en_nxt = bar_en_r;
    cmd_en_nxt = cmd_en_r;
    own_en_nxt = own_en_r;
    mir_en_nxt = mir_en_r;
    if (wr_cs && cfg_req.be[1]) begin
      bar_en_nxt = wd[`ULSH_BAR_EN_BIT]; // see R20
      cmd_en_nxt = wd[`ULSH_CMD_EN_BIT]; // see R21
      own_en_nxt = wd[`ULSH_OWN_EN_BIT]; // see R22
    end
    if (wr_cs && cfg_req.be[0]) begin
      mir_en_nxt = wd[5:0]; // see R23
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R8
    if (!resetn) begin
      bar_en_r <= cs_rst[`ULSH_BAR_EN_BIT];
      cmd_en_r <= cs_rst[`ULSH_CMD_EN_BIT];
      own_en_r <= cs_rst[`ULSH_OWN_EN_BIT];
      mir_en_r <= cs_rst[5:0];
    end else begin
      bar_en_r <= bar_en_nxt;
      cmd_en_r <= cmd_en_nxt;
      own_en_r <= own_en_nxt;
      mir_en_r <= mir_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base address write flag, set wins over clear
  always_comb begin
    bar_clr = wr_cs & wd[`ULSH_BAR_FLAG_BIT]; // see R12 see R25
    bar_flag_nxt = bar_flag_r & ~bar_clr;
    if (bar_write) begin
      bar_flag_nxt = 1'b1; // see R9
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R8
    if (!resetn) begin
      bar_flag_r <= cs_rst[`ULSH_BAR_FLAG_BIT];
    end else begin
      bar_flag_r <= bar_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register write flag, set wins over clear
  always_comb begin
    cmd_clr = wr_cs & wd[`ULSH_CMD_FLAG_BIT]; // see R12 see R25
    cmd_flag_nxt = cmd_flag_r & ~cmd_clr;
    if (cmd_write) begin
      cmd_flag_nxt = 1'b1; // see R10
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R8
    if (!resetn) begin
      cmd_flag_r <= cs_rst[`ULSH_CMD_FLAG_BIT];
    end else begin
      cmd_flag_r <= cmd_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ownership change flag, either direction
  always_comb begin
    own_clr = wr_cs & wd[`ULSH_OWN_FLAG_BIT]; // see R12 see R25
    own_chg = os_own_nxt != os_own_r;
    own_flag_nxt = own_flag_r & ~own_clr;
    if (own_chg) begin
      own_flag_nxt = 1'b1; // see R11
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R8
    if (!resetn) begin
      own_flag_r <= cs_rst[`ULSH_OWN_FLAG_BIT];
    end else begin
      own_flag_r <= own_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host status mirror, read-only
  always_comb begin
    mirror_nxt = host_status_flags; // see R13 see R14 see R15 see R16 see R17 see R18 see R19
  end

  always_ff @(posedge sys_clk or negedge resetn) begin // see R8
    if (!resetn) begin
      mirror_r <= cs_rst[21:16];
    end else begin
      mirror_r <= mirror_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data and valid stand one cycle
  always_comb begin
    rvalid_nxt = cfg_req.rd;
    rdata_nxt = 32'h00000000;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        `ULSH_CAP_OFFSET: begin
          rdata_nxt = cap_val;
        end
        `ULSH_CS_OFFSET: begin
          rdata_nxt = cs_val;
        end
        default: begin
          rdata_nxt = 32'h00000000; // see R25
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SMI output
  assign mir = '{en: mir_en_r, flag: mirror_r};

  ulsh_smi_gate u_gate (
    .mir(mir),
    .any_hit(mir_hit)
  );

  always_comb begin
    bar_hit = bar_en_r & bar_flag_r; // see R20
    cmd_hit = cmd_en_r & cmd_flag_r; // see R21
    own_hit = own_en_r & own_flag_r; // see R22
    smi_nxt = bar_hit | cmd_hit | own_hit | mir_hit; // see R23 see R24
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smi_r <= 1'b0;
    end else begin
      smi_r <= smi_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign smi_out = smi_r;
  assign os_owned = os_own_r;
  assign fw_owned = fw_own_r;

endmodule : ulsh_legacy_handoff

// ### testbench/ulsh_legacy_handoff_checker.sv
// Checker for the legacy-support register pair
// Assumes it is bound to ulsh_legacy_handoff
`timescale 1ns/10ps
module ulsh_checker
  import ulsh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire ulsh_cfg_req_t cfg_req,
  input wire logic [5:0] host_status_flags,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic smi_out,
  input wire logic os_owned,
  input wire logic fw_owned
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire rcap = cfg_req.rd && cfg_req.addr == 8'h68;
  wire rcs = cfg_req.rd && cfg_req.addr == 8'h6c;
  wire wcap = cfg_req.wr && cfg_req.addr == 8'h68;
  ////////////////////////////////////////////////////////////
  cap_const_a: assert property (rcap |=>
    cfg_rdata[15:0] == 16'h0001 && cfg_rdata[31:25] == 7'h0 && cfg_rdata[23:17] == 7'h0) else $error("cap bits");
  cap_own_a: assert property (rcap |=> cfg_rdata[24] == $past(os_owned)) else $error("os bit read");
  os_set_a: assert property (wcap && cfg_req.be[3] |=> os_owned == $past(cfg_req.wdata[24])) else $error("os");
  fw_set_a: assert property (wcap && cfg_req.be[2] |=> fw_owned == $past(cfg_req.wdata[16])) else $error("fw");
  own_hold_a: assert property (!wcap |=> $stable(os_owned) && $stable(fw_owned)) else $error("own moved");
  mirror_rd_a: assert property (rcs && $past(resetn) |=>
    cfg_rdata[21:16] == $past(host_status_flags, 2)) else $error("mirror");
  cs_resv_a: assert property (rcs |=> cfg_rdata[28:22] == 7'h0 && cfg_rdata[12:6] == 7'h0) else $error("resv");
  rvalid_lag_a: assert property (cfg_rvalid == $past(cfg_req.rd)) else $error("rvalid");
  idle_zero_a: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0) else $error("rdata idle");
  cover property (rcs);
  cover property ($rose(smi_out));
  cover property ($rose(os_owned));
endmodule : ulsh_checker
bind ulsh_legacy_handoff ulsh_checker chk_i (.sys_clk, .resetn, .cfg_req, .host_status_flags, .cfg_rdata,
  .cfg_rvalid, .smi_out, .os_owned, .fw_owned);

// ### testbench/ulsh_legacy_handoff_test.sv
// Bench for the legacy-support register pair
// Assumes the design, package and bound checker are compiled first
`timescale 1ns/10ps
module ulsh_legacy_handoff_test
  import ulsh_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  ulsh_cfg_req_t cfg_req = '0;
  logic bar_write = 1'b0;
  logic cmd_write = 1'b0;
  logic [5:0] host_status_flags = 6'h0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid, smi_out, os_owned, fw_owned;
  int bad_count = 0;
  int n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  ulsh_legacy_handoff uut (.sys_clk, .resetn, .cfg_req, .bar_write, .cmd_write, .host_status_flags,
    .cfg_rdata, .cfg_rvalid, .smi_out, .os_owned, .fw_owned);
  ////////////////////////////////////////////////////////////
  task test_done;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge sys_clk);
    cfg_req <= '{1'b1, 1'b0, a, b, d};
    @(posedge sys_clk);
    cfg_req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    cfg_req <= '{1'b0, 1'b1, a, 4'h0, 32'h0};
    @(posedge sys_clk);
    cfg_req.rd <= 1'b0;
    #1 chk(cfg_rdata, e);
  endtask : rd
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'h68, 32'h00000001);
    rd(8'h6c, 32'h0);
    wr(8'h68, 4'hf, 32'hffffffff);
    rd(8'h68, 32'h01010001);
    chk(32'({os_owned, fw_owned}), 32'h3);
    rd(8'h6c, 32'h20000000);
    wr(8'h6c, 4'hf, 32'h0);
    rd(8'h6c, 32'h20000000);
    wr(8'h6c, 4'hf, 32'hffffffff);
    rd(8'h6c, 32'h0000e03f);
    $display("register tests done");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      bar_write <= (i == 0);
      cmd_write <= (i == 1);
      @(posedge sys_clk);
      {bar_write, cmd_write} <= 2'h0;
      if (i == 2) wr(8'h68, 4'h8, 32'h0);
      rd(8'h6c, 32'h0000e03f | (32'h1 << (31 - i)));
      chk(32'(smi_out), 32'h1);
      wr(8'h6c, 4'h8, 32'h1 << (31 - i));
      rd(8'h6c, 32'h0000e03f);
      chk(32'(smi_out), 32'h0);
    end
    @(posedge sys_clk);
    bar_write <= 1'b1;
    cfg_req <= '{1'b1, 1'b0, 8'h6c, 4'h8, 32'h80000000};
    @(posedge sys_clk);
    bar_write <= 1'b0;
    cfg_req.wr <= 1'b0;
    rd(8'h6c, 32'h8000e03f);
    chk(32'(smi_out), 32'h1);
    wr(8'h6c, 4'h8, 32'h80000000);
    $display("event tests done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      host_status_flags <= 6'(1 << i);
      rd(8'h6c, 32'h0000e03f | (32'h1 << (16 + i)));
      chk(32'(smi_out), 32'h1);
    end
    wr(8'h6c, 4'h4, 32'h003f0000);
    rd(8'h6c, 32'h0020e03f);
    wr(8'h6c, 4'h3, 32'h0);
    rd(8'h6c, 32'h00200000);
    chk(32'(smi_out), 32'h0);
    wr(8'h68, 4'h8, 32'h01000000);
    wr(8'h68, 4'h4, 32'h0);
    rd(8'h68, 32'h01000001);
    chk(32'({os_owned, fw_owned}), 32'h2);
    wr(8'h70, 4'hf, 32'hffffffff);
    rd(8'h70, 32'h0);
    $display("mirror tests done");
    test_done();
  end
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule : ulsh_legacy_handoff_test
